// [src/fsp_host.sv]
// Functional notes
// - Every sector byte write carries the sector on the upper address lines.
// - The host loads all 128 bytes of a sector unless the byte load window runs out first; it then sets blc_err and polls.
// - Successive byte loads stay within the byte load window.
// - Completion is judged by the toggle bit not changing between reads.
// - Polling reads keep one constant address.
// - Command data is hex on eight data lines, addresses on fifteen lines.
`timescale 1ns/1ns
`default_nettype none

module fsp_host
  import fsp_pkg::*;
#(
  parameter int WC_CYCLES = CYC_WC,
  parameter logic [CMD_ADDR_W-1:0] SEQ_ADDR_A = 15'h0001,
  parameter logic [CMD_ADDR_W-1:0] SEQ_ADDR_B = 15'h0002,
  parameter logic [DATA_W-1:0] SEQ_DATA_A = 8'h01,
  parameter logic [DATA_W-1:0] SEQ_DATA_B = 8'h02,
  parameter logic [DATA_W-1:0] CMD_PROGRAM = 8'h10,
  parameter logic [DATA_W-1:0] CMD_ID_ENTER = 8'h11,
  parameter logic [DATA_W-1:0] CMD_ID_EXIT = 8'h12,
  parameter logic [DATA_W-1:0] CMD_LOCK_LO = 8'h13,
  parameter logic [DATA_W-1:0] CMD_LOCK_HI = 8'h14
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic req_valid,
  output logic req_ready,
  input wire fsp_req_s req,
  input wire logic wr_valid,
  output logic wr_ready,
  input wire logic [DATA_W-1:0] wr_data,
  output logic rd_valid,
  output logic [DATA_W-1:0] rd_data,
  output fsp_sta_s sta,
  output fsp_bus_s bus,
  input wire logic [DATA_W-1:0] dq_i
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations.
  typedef enum logic [2:0] {ST_IDLE, ST_CMD, ST_LOAD, ST_POLL, ST_READ, ST_ID_RD} fsp_state_e;
  typedef enum logic [2:0] {PH_IDLE, PH_WSET, PH_WLOW, PH_WHIGH, PH_RLOW, PH_RHIGH} fsp_phase_e;

  fsp_state_e state_q;
  fsp_phase_e ph_q;
  fsp_req_s req_q;
  logic [3:0] cnt_q;
  logic acc_done_q;
  logic [DATA_W-1:0] rdat_q;
  logic [DATA_W-1:0] dq_s1_q;
  logic [DATA_W-1:0] dq_s2_q;
  logic [DATA_W-1:0] dq_s3_q;
  logic [1:0] seq_q;
  logic [6:0] idx_q;
  logic exit_q;
  logic prev_q;
  logic have_prev_q;
  logic [10:0] blc_cnt_q;
  logic [31:0] wc_cnt_q;
  logic [7:0] load_cnt_q;
  logic accept;
  logic ph_idle;
  logic acc_start;
  logic acc_wr;
  logic [ADDR_W-1:0] acc_addr;
  logic [DATA_W-1:0] acc_data;
  logic [DATA_W-1:0] cmd_code;
  logic [ADDR_W-1:0] poll_addr;
  logic fifo_valid;
  logic fifo_pop;
  logic [DATA_W-1:0] fifo_data;
  logic blc_late;
  logic wc_over;

  ////////////////////////////////////////////////////////////////////////////
  // Sector data buffer.
  fsp_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .mclk(mclk),
    .nrst(nrst),
    .in_valid(wr_valid),
    .in_ready(wr_ready),
    .in_data(wr_data),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Data line synchroniser.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      dq_s1_q <= 8'h00;
      dq_s2_q <= 8'h00;
      dq_s3_q <= 8'h00;
    end else begin
      dq_s1_q <= dq_i;
      dq_s2_q <= dq_s1_q;
      dq_s3_q <= dq_s2_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Access selection.
  assign accept = req_valid && req_ready;
  assign ph_idle = (ph_q == PH_IDLE) && !acc_done_q;
  assign blc_late = (blc_cnt_q >= 11'(CYC_BLC));
  assign wc_over = (wc_cnt_q >= 32'(WC_CYCLES));

  always_comb begin
    cmd_code = CMD_PROGRAM;
    unique case (req_q.op)
      FSP_OP_PROGRAM: cmd_code = CMD_PROGRAM;
      FSP_OP_IDENT: cmd_code = exit_q ? CMD_ID_EXIT : CMD_ID_ENTER;
      FSP_OP_LOCK_LO: cmd_code = CMD_LOCK_LO;
      FSP_OP_LOCK_HI: cmd_code = CMD_LOCK_HI;
      FSP_OP_READ: cmd_code = CMD_PROGRAM;
      default: cmd_code = CMD_PROGRAM;
    endcase
    poll_addr = (req_q.op == FSP_OP_PROGRAM) ? {req_q.addr[ADDR_W-1:SECTOR_LSB], 7'h00} : req_q.addr;
  end

  always_comb begin
    acc_start = 1'b0;
    acc_wr = 1'b0;
    acc_addr = '0;
    acc_data = '0;
    fifo_pop = 1'b0;
    unique case (state_q)
      ST_CMD: begin
        acc_wr = 1'b1;
        acc_start = ph_idle;
        acc_addr = {2'b00, (seq_q == 2'd1) ? SEQ_ADDR_B : SEQ_ADDR_A};
        acc_data = (seq_q == 2'd0) ? SEQ_DATA_A : ((seq_q == 2'd1) ? SEQ_DATA_B : cmd_code);
      end
      ST_LOAD: begin
        acc_wr = 1'b1;
        acc_start = ph_idle && fifo_valid && !blc_late;
        acc_addr = {req_q.addr[ADDR_W-1:SECTOR_LSB], idx_q};
        acc_data = fifo_data;
        fifo_pop = acc_start;
      end
      ST_POLL: begin
        acc_start = ph_idle;
        acc_addr = poll_addr;
      end
      ST_READ: begin
        acc_start = ph_idle;
        acc_addr = req_q.addr;
      end
      ST_ID_RD: begin
        acc_start = ph_idle;
        acc_addr = {16'h0000, idx_q[0]};
      end
      ST_IDLE: begin
        acc_start = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus cycle engine.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      ph_q <= PH_IDLE;
      cnt_q <= 4'h0;
      bus <= BUS_RESET;
      acc_done_q <= 1'b0;
      rdat_q <= 8'h00;
    end else begin
      acc_done_q <= 1'b0;
      cnt_q <= (cnt_q == 4'hf) ? cnt_q : cnt_q + 4'h1;
      unique case (ph_q)
        PH_IDLE: begin
          cnt_q <= 4'h0;
          bus.we_n <= 1'b1;
          if (acc_start) begin
            bus.addr <= acc_addr;
            bus.ce_n <= 1'b0;
            bus.dq_o <= acc_data;
            bus.dq_oe <= acc_wr;
            bus.oe_n <= acc_wr;
            ph_q <= acc_wr ? PH_WSET : PH_RLOW;
          end else begin
            bus.ce_n <= 1'b1;
            bus.oe_n <= 1'b1;
            bus.dq_oe <= 1'b0;
          end
        end
        PH_WSET: begin
          if (cnt_q == 4'(CYC_AS - 1)) begin
            ph_q <= PH_WLOW;
            cnt_q <= 4'h0;
            bus.we_n <= 1'b0;
          end
        end
        PH_WLOW: begin
          if (cnt_q == 4'(CYC_WP - 1)) begin
            ph_q <= PH_WHIGH;
            cnt_q <= 4'h0;
            bus.we_n <= 1'b1;
          end
        end
        PH_WHIGH: begin
          if (cnt_q == 4'(CYC_WPH - 1)) begin
            ph_q <= PH_IDLE;
            acc_done_q <= 1'b1;
            bus.ce_n <= 1'b1;
            bus.dq_oe <= 1'b0;
          end
        end
        PH_RLOW: begin
          if (cnt_q >= 4'(CYC_RD_WAIT) && dq_s2_q == dq_s3_q) begin
            rdat_q <= dq_s3_q;
            ph_q <= PH_RHIGH;
            cnt_q <= 4'h0;
            bus.oe_n <= 1'b1;
          end
        end
        PH_RHIGH: begin
          if (cnt_q == 4'(CYC_OEHP - 1)) begin
            ph_q <= PH_IDLE;
            acc_done_q <= 1'b1;
            bus.ce_n <= 1'b1;
          end
        end
        default: ph_q <= PH_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Byte load window and program cycle timers.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      blc_cnt_q <= 11'h000;
      wc_cnt_q <= 32'h00000000;
    end else begin
      if (state_q != ST_LOAD || acc_start) begin
        blc_cnt_q <= 11'h000;
      end else if (!blc_late) begin
        blc_cnt_q <= blc_cnt_q + 11'h001;
      end
      if (state_q != ST_POLL) begin
        wc_cnt_q <= 32'h00000000;
      end else if (!wc_over) begin
        wc_cnt_q <= wc_cnt_q + 32'h00000001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Operation sequencer.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      state_q <= ST_IDLE;
      req_q <= '{op: FSP_OP_READ, addr: 17'h00000};
      req_ready <= 1'b1;
      seq_q <= 2'd0;
      idx_q <= 7'h00;
      exit_q <= 1'b0;
      prev_q <= 1'b0;
      have_prev_q <= 1'b0;
      rd_valid <= 1'b0;
      rd_data <= 8'h00;
      sta <= STA_RESET;
    end else begin
      rd_valid <= 1'b0;
      unique case (state_q)
        ST_IDLE: begin
          if (accept) begin
            req_q <= req;
            req_ready <= 1'b0;
            sta.busy <= 1'b1;
            seq_q <= 2'd0;
            idx_q <= 7'h00;
            exit_q <= 1'b0;
            have_prev_q <= 1'b0;
            sta.blc_err <= 1'b0;
            sta.wc_timeout <= 1'b0;
            state_q <= (req.op == FSP_OP_READ) ? ST_READ : ST_CMD;
          end
        end
        ST_CMD: begin
          if (acc_done_q) begin
            seq_q <= seq_q + 2'd1;
            if (seq_q == 2'd2) begin
              if (req_q.op == FSP_OP_PROGRAM) begin
                state_q <= ST_LOAD;
              end else if (req_q.op == FSP_OP_IDENT) begin
                state_q <= exit_q ? ST_IDLE : ST_ID_RD;
                req_ready <= exit_q;
                sta.busy <= !exit_q;
              end else begin
                state_q <= ST_POLL;
              end
            end
          end
        end
        ST_LOAD: begin
          if (acc_done_q) begin
            idx_q <= idx_q + 7'h01;
            if (idx_q == 7'(SECTOR_BYTES - 1)) begin
              state_q <= ST_POLL;
            end
          end else if (ph_q == PH_IDLE && blc_late) begin
            sta.blc_err <= 1'b1;
            state_q <= ST_POLL;
          end
        end
        ST_POLL: begin
          if (acc_done_q) begin
            prev_q <= rdat_q[TOGGLE_BIT];
            have_prev_q <= 1'b1;
            if ((have_prev_q && rdat_q[TOGGLE_BIT] == prev_q) || wc_over) begin
              sta.wc_timeout <= !(have_prev_q && rdat_q[TOGGLE_BIT] == prev_q);
              state_q <= ST_IDLE;
              req_ready <= 1'b1;
              sta.busy <= 1'b0;
            end
          end
        end
        ST_READ: begin
          if (acc_done_q) begin
            rd_valid <= 1'b1;
            rd_data <= rdat_q;
            state_q <= ST_IDLE;
            req_ready <= 1'b1;
            sta.busy <= 1'b0;
          end
        end
        ST_ID_RD: begin
          if (acc_done_q) begin
            rd_valid <= 1'b1;
            rd_data <= rdat_q;
            idx_q <= idx_q + 7'h01;
            if (idx_q[0]) begin
              exit_q <= 1'b1;
              seq_q <= 2'd0;
              state_q <= ST_CMD;
            end
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      load_cnt_q <= 8'h00;
    end else if (state_q == ST_CMD) begin
      load_cnt_q <= 8'h00;
    end else if (state_q == ST_LOAD && acc_start) begin
      load_cnt_q <= load_cnt_q + 8'h01;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  sequence we_pulse_s;
    !bus.we_n ##1 !bus.we_n ##1 bus.we_n;
  endsequence

  sequence we_recover_s;
    bus.we_n [*2];
  endsequence

  we_pulse_width_a: assert property ($fell(bus.we_n) |-> we_pulse_s ##0 we_recover_s)
    else $error("write strobe width or recovery wrong");
  sector_addr_hold_a: assert property ((state_q == ST_LOAD && !bus.we_n) |->
    bus.addr[ADDR_W-1:SECTOR_LSB] == req_q.addr[ADDR_W-1:SECTOR_LSB])
    else $error("sector address lost during load");
  full_sector_a: assert property ((state_q == ST_LOAD ##1 state_q == ST_POLL && !sta.blc_err) |->
    load_cnt_q == 8'(SECTOR_BYTES))
    else $error("sector left with bytes missing");
  load_window_a: assert property ((state_q == ST_LOAD && blc_cnt_q == 11'(CYC_BLC)) |->
    ##[1:6] (sta.blc_err || state_q != ST_LOAD))
    else $error("byte load window overrun unflagged");
  unlock_first_a: assert property ($rose(state_q == ST_LOAD) |-> $past(state_q) == ST_CMD)
    else $error("load entered without unlock");
  poll_addr_const_a: assert property ((state_q == ST_POLL && !bus.ce_n) |-> bus.addr == poll_addr)
    else $error("poll address varied");
  toggle_judge_a: assert property ((state_q == ST_POLL && acc_done_q && !wc_over && !have_prev_q) |=>
    state_q == ST_POLL)
    else $error("completion judged from a single read");
  no_early_req_a: assert property ((state_q == ST_POLL) |-> !req_ready)
    else $error("request taken while programming");
  cmd_lines_a: assert property ((state_q == ST_CMD && !bus.we_n) |->
    bus.addr[ADDR_W-1:CMD_ADDR_W] == 2'b00 && bus.dq_oe)
    else $error("command cycle drives upper lines");
  oe_guard_a: assert property ((!bus.we_n && !bus.ce_n) |-> bus.oe_n)
    else $error("output strobe low during write");
  id_addr_a: assert property ((state_q == ST_ID_RD && !bus.oe_n) |->
    bus.addr[ADDR_W-1:1] == 16'h0000 && bus.addr[0] == idx_q[0])
    else $error("identification read address wrong");
  poll_toggle_a: assert property (($rose(state_q == ST_POLL)) |-> ##[1:14] $fell(bus.oe_n))
    else $error("no status read after program start");

endmodule : fsp_host

`default_nettype wire

// [pkg/fsp_pkg.sv]
package fsp_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Clock and pin timing, in their printed units and as cycle counts.
  localparam int CLK_NS = 100;
  localparam int T_AS_NS = 10;
  localparam int T_WP_NS = 200;
  localparam int T_WPH_NS = 200;
  localparam int T_ACC_NS = 250;
  localparam int T_OEHP_NS = 150;
  localparam int T_BLC_US = 150;
  localparam int T_WC_MS = 20;
  localparam int CYC_AS = ((T_AS_NS + CLK_NS - 1) / CLK_NS) < 1 ? 1 : ((T_AS_NS + CLK_NS - 1) / CLK_NS);
  localparam int CYC_WP = ((T_WP_NS + CLK_NS - 1) / CLK_NS) < 1 ? 1 : ((T_WP_NS + CLK_NS - 1) / CLK_NS);
  localparam int CYC_WPH = ((T_WPH_NS + CLK_NS - 1) / CLK_NS) < 1 ? 1 : ((T_WPH_NS + CLK_NS - 1) / CLK_NS);
  localparam int CYC_ACC = ((T_ACC_NS + CLK_NS - 1) / CLK_NS) < 1 ? 1 : ((T_ACC_NS + CLK_NS - 1) / CLK_NS);
  localparam int CYC_OEHP = ((T_OEHP_NS + CLK_NS - 1) / CLK_NS) < 1 ? 1 : ((T_OEHP_NS + CLK_NS - 1) / CLK_NS);
  localparam int CYC_BLC = (T_BLC_US * 1000) / CLK_NS;
  localparam int CYC_WC = (T_WC_MS * 1000000) / CLK_NS;
  localparam int SYNC_LAT = 2;
  localparam int CYC_RD_WAIT = CYC_ACC + SYNC_LAT;

  ////////////////////////////////////////////////////////////////////////////
  // Array geometry and status bit positions.
  localparam int ADDR_W = 17;
  localparam int DATA_W = 8;
  localparam int CMD_ADDR_W = 15;
  localparam int SECTOR_LSB = 7;
  localparam int SECTOR_BYTES = 128;
  localparam int TOGGLE_BIT = 6;
  localparam int POLL_BIT = 7;
  localparam int FIFO_DEPTH = 8;

  ////////////////////////////////////////////////////////////////////////////
  // Types.
  typedef enum logic [2:0] {
    FSP_OP_PROGRAM,
    FSP_OP_READ,
    FSP_OP_IDENT,
    FSP_OP_LOCK_LO,
    FSP_OP_LOCK_HI
  } fsp_op_e;

  typedef struct packed {
    fsp_op_e op;
    logic [ADDR_W-1:0] addr;
  } fsp_req_s;

  typedef struct packed {
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] dq_o;
    logic dq_oe;
  } fsp_bus_s;

  typedef struct packed {
    logic busy;
    logic blc_err;
    logic wc_timeout;
  } fsp_sta_s;

  localparam fsp_bus_s BUS_RESET = '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, addr: 17'h00000, dq_o: 8'h00, dq_oe: 1'b0};
  localparam fsp_sta_s STA_RESET = '{busy: 1'b0, blc_err: 1'b0, wc_timeout: 1'b0};

endpackage : fsp_pkg

// [src/fsp_fifo.sv]
`timescale 1ns/1ns
`default_nettype none

module fsp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int AW = (DEPTH < 2) ? 1 : $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_q;
  logic [AW-1:0] rd_ptr_q;
  logic [AW:0] count_q;
  logic [AW:0] count_d;
  logic push;
  logic pop;

  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_valid = (count_q != '0);
  assign out_data = mem[rd_ptr_q];

  always_comb begin
    count_d = count_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  end

  // Storage carries no reset; only words below the count are ever read.
  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wr_ptr_q] <= in_data;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
      in_ready <= 1'b0;
    end else begin
      count_q <= count_d;
      in_ready <= (count_d < (AW+1)'(DEPTH));
      if (push) begin
        wr_ptr_q <= (wr_ptr_q == AW'(DEPTH - 1)) ? '0 : wr_ptr_q + 1'b1;
      end
      if (pop) begin
        rd_ptr_q <= (rd_ptr_q == AW'(DEPTH - 1)) ? '0 : rd_ptr_q + 1'b1;
      end
    end
  end

endmodule : fsp_fifo

`default_nettype wire

// [sim/fsp_flash_model.sv]
`timescale 1ns/1ns
`default_nettype none

module fsp_flash_model
  import fsp_pkg::*;
#(
  parameter int BLC_CYC = 1400,
  parameter int PROG_CYC = 40,
  parameter int ACC_NS = 250,
  parameter int BOOT_BYTES = 8192,
  parameter logic [DATA_W-1:0] MAKER_ID = 8'h5c,
  parameter logic [DATA_W-1:0] PART_ID = 8'h3a
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic stall,
  input wire fsp_bus_s bus,
  output logic [DATA_W-1:0] dq
);
  // Both identification values are arbitrary; the command codes match the host defaults.
  localparam logic [CMD_ADDR_W-1:0] SA = 15'h0001;
  localparam logic [CMD_ADDR_W-1:0] SB = 15'h0002;
  ////////////////////////////////////////////////////////////////
  logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
  logic [DATA_W-1:0] lbuf [0:SECTOR_BYTES-1];
  logic [SECTOR_BYTES-1:0] lmask;
  logic [ADDR_W-SECTOR_LSB-1:0] sector;
  logic [ADDR_W-1:0] poll_addr;
  logic [DATA_W-1:0] dout;
  logic [DATA_W-1:0] last_wr;
  logic [1:0] seq;
  logic we_q, rd_q, loading, busy, ident, lock_lo, lock_hi, tog, polled;
  int nload, idle, bcnt, viol;
  wire rd_act = !bus.ce_n && !bus.oe_n && bus.we_n;
  wire wr_evt = bus.we_n && !we_q && !bus.ce_n;
  wire [CMD_ADDR_W-1:0] cmd_a = bus.addr[CMD_ADDR_W-1:0];
  wire rd_on;

  // Data is valid one access time after the read starts; otherwise the lines show its inverse.
  assign #(ACC_NS) rd_on = rd_act;
  assign dq = rd_on ? dout : ~dout;

  function automatic logic locked(input logic [ADDR_W-1:0] a);
    return (lock_lo && a < BOOT_BYTES) || (lock_hi && a >= (1 << ADDR_W) - BOOT_BYTES);
  endfunction : locked

  initial begin
    for (int i = 0; i < (1 << ADDR_W); i++) mem[i] = 8'hff;
    lock_lo = 1'b0;
    lock_hi = 1'b0;
    tog = 1'b1;
    viol = 0;
    nload = 0;
    dout = 8'h00;
  end

  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      ident <= 1'b0;
      {seq, loading, busy, polled} <= '0;
      {we_q, rd_q} <= 2'b10;
    end else begin
      we_q <= bus.we_n;
      rd_q <= rd_act;
      if (rd_act && !rd_q) begin
        if (busy) begin
          dout <= {~last_wr[7], ~tog, 6'h00};
          tog <= ~tog;
          polled <= 1'b1;
          poll_addr <= bus.addr;
          if (polled && bus.addr != poll_addr) viol <= viol + 1;
        end else if (ident && bus.addr[ADDR_W-1:1] == '0) begin
          dout <= bus.addr[0] ? PART_ID : MAKER_ID;
        end else begin
          dout <= mem[bus.addr];
        end
      end
      if (loading && nload > 0) begin
        idle <= idle + 1;
        if (nload == SECTOR_BYTES || idle >= BLC_CYC) begin
          {loading, polled, busy} <= 3'b001;
          bcnt <= 0;
        end
      end
      if (busy) begin
        bcnt <= bcnt + 1;
        if (bcnt >= PROG_CYC && !stall) begin
          busy <= 1'b0;
          for (int k = 0; k < SECTOR_BYTES; k++) begin
            if (!locked({sector, 7'(k)})) mem[{sector, 7'(k)}] <= lmask[k] ? lbuf[k] : ~mem[{sector, 7'(k)}];
          end
        end
      end
      if (wr_evt && !busy) begin
        if (loading) begin
          if (nload == 0) sector <= bus.addr[ADDR_W-1:SECTOR_LSB];
          else if (bus.addr[ADDR_W-1:SECTOR_LSB] != sector) viol <= viol + 1;
          lbuf[bus.addr[SECTOR_LSB-1:0]] <= bus.dq_o;
          lmask[bus.addr[SECTOR_LSB-1:0]] <= 1'b1;
          last_wr <= bus.dq_o;
          nload <= nload + 1;
          idle <= 0;
        end else begin
          case (seq)
            2'd0: seq <= (cmd_a == SA && bus.dq_o == 8'h01) ? 2'd1 : 2'd0;
            2'd1: seq <= (cmd_a == SB && bus.dq_o == 8'h02) ? 2'd2 : 2'd0;
            default: begin
              seq <= 2'd0;
              if (cmd_a == SA && bus.dq_o == 8'h10) begin
                loading <= 1'b1;
                nload <= 0;
                idle <= 0;
                lmask <= '0;
              end
              if (cmd_a == SA && bus.dq_o == 8'h11) ident <= 1'b1;
              if (cmd_a == SA && bus.dq_o == 8'h12) ident <= 1'b0;
              if (cmd_a == SA && bus.dq_o == 8'h13) lock_lo <= 1'b1;
              if (cmd_a == SA && bus.dq_o == 8'h14) lock_hi <= 1'b1;
            end
          endcase
        end
      end
    end
  end
endmodule : fsp_flash_model

`default_nettype wire

// [sim/sector_flash_program_protocol_tb.sv]
`timescale 1ns/1ns
`default_nettype none
`define CHK(what, exp, got) begin \
  comparisons++; \
  if ((got) !== (exp)) begin \
    failures++; \
    $display("[ERR] %s expected %h seen %h", what, exp, got); \
  end \
end

module sector_flash_program_protocol_tb;
  import fsp_pkg::*;
  // Both identification values are arbitrary and match the flash model's defaults.
  localparam logic [DATA_W-1:0] MAKER = 8'h5c;
  localparam logic [DATA_W-1:0] PART = 8'h3a;
  logic mclk, nrst, req_valid, req_ready, wr_valid, wr_ready, rd_valid, stall, saw_full;
  logic [DATA_W-1:0] wr_data;
  logic [DATA_W-1:0] rd_data;
  logic [DATA_W-1:0] dq_i;
  fsp_req_s req;
  fsp_sta_s sta;
  fsp_bus_s bus;
  int failures, comparisons;

  fsp_host #(.WC_CYCLES(200)) i_dut (
    .mclk(mclk),
    .nrst(nrst),
    .req_valid(req_valid),
    .req_ready(req_ready),
    .req(req),
    .wr_valid(wr_valid),
    .wr_ready(wr_ready),
    .wr_data(wr_data),
    .rd_valid(rd_valid),
    .rd_data(rd_data),
    .sta(sta),
    .bus(bus),
    .dq_i(dq_i)
  );

  fsp_flash_model #(.MAKER_ID(MAKER), .PART_ID(PART)) i_flash (
    .mclk(mclk),
    .nrst(nrst),
    .stall(stall),
    .bus(bus),
    .dq(dq_i)
  );

  ////////////////////////////////////////////////////////////////
  task automatic finish_test();
    $display("Counts: %0d comparisons, %0d failures", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : finish_test

  task automatic send_req(input fsp_op_e op, input logic [ADDR_W-1:0] a);
    req_valid = 1'b1;
    req = '{op: op, addr: a};
    do @(posedge mclk); while (!req_ready);
    @(negedge mclk);
    req_valid = 1'b0;
  endtask : send_req

  task automatic wait_idle();
    int n;
    n = 0;
    while (req_ready !== 1'b1 && n < 5000) begin
      @(negedge mclk);
      n++;
    end
    `CHK("req_ready", 1'b1, req_ready)
  endtask : wait_idle

  task automatic push(input int n, input logic [7:0] s);
    for (int k = 0; k < n; k++) begin
      wr_valid = 1'b1;
      wr_data = s + 8'(k);
      do begin
        @(posedge mclk);
        if (!wr_ready) saw_full = 1'b1;
      end while (!wr_ready);
      @(negedge mclk);
    end
    wr_valid = 1'b0;
  endtask : push

  task automatic read_chk(input logic [ADDR_W-1:0] a, input logic [7:0] exp);
    int n;
    n = 0;
    send_req(FSP_OP_READ, a);
    while (rd_valid !== 1'b1 && n < 100) begin
      @(negedge mclk);
      n++;
    end
    `CHK("rd_valid", 1'b1, rd_valid)
    `CHK("rd_data", exp, rd_data)
    wait_idle();
  endtask : read_chk

  task automatic do_program(input logic [9:0] sec, input logic [7:0] s, input int n, input logic tmo);
    fork
      push(n, s);
      send_req(FSP_OP_PROGRAM, {sec, 7'h00});
    join
    `CHK("busy", 1'b1, sta.busy)
    wait_idle();
    `CHK("busy", 1'b0, sta.busy)
    `CHK("blc_err", (n < SECTOR_BYTES), sta.blc_err)
    `CHK("wc_timeout", tmo, sta.wc_timeout)
    `CHK("bytes loaded", n, i_flash.nload)
    `CHK("bus violations", 0, i_flash.viol)
  endtask : do_program

  ////////////////////////////////////////////////////////////////
  task automatic t_reset();
    `CHK("bus", BUS_RESET, bus)
    `CHK("req_ready", 1'b1, req_ready)
    `CHK("wr_ready", 1'b0, wr_ready)
    `CHK("sta", STA_RESET, sta)
    nrst = 1'b1;
    repeat (2) @(negedge mclk);
    `CHK("wr_ready", 1'b1, wr_ready)
    $display("test reset done");
  endtask : t_reset

  task automatic t_program();
    saw_full = 1'b0;
    do_program(10'h010, 8'h20, SECTOR_BYTES, 1'b0);
    do_program(10'h011, 8'h40, SECTOR_BYTES, 1'b0);
    `CHK("fifo full seen", 1'b1, saw_full)
    read_chk(17'h00800, 8'h20);
    read_chk(17'h0087f, 8'h9f);
    read_chk(17'h008ff, 8'hbf);
    $display("test program done");
  endtask : t_program

  task automatic t_ident();
    logic [7:0] q [$];
    int n;
    n = 0;
    send_req(FSP_OP_IDENT, '0);
    while (req_ready !== 1'b1 && n < 1000) begin
      if (rd_valid === 1'b1) q.push_back(rd_data);
      @(negedge mclk);
      n++;
    end
    `CHK("ident bytes", 2, q.size())
    `CHK("maker code", MAKER, q[0])
    `CHK("part code", PART, q[1])
    read_chk(17'h00001, 8'hff);
    $display("test ident done");
  endtask : t_ident

  task automatic t_lock();
    fsp_op_e ops [2] = '{FSP_OP_LOCK_LO, FSP_OP_LOCK_HI};
    logic [9:0] secs [2] = '{10'h000, 10'h3ff};
    for (int i = 0; i < 2; i++) begin
      send_req(ops[i], {secs[i], 7'h00});
      wait_idle();
      do_program(secs[i], 8'h00, SECTOR_BYTES, 1'b0);
      read_chk({secs[i], 7'h05}, 8'hff);
    end
    $display("test lock done");
  endtask : t_lock

  task automatic t_timeout();
    stall = 1'b1;
    do_program(10'h100, 8'h60, SECTOR_BYTES, 1'b1);
    stall = 1'b0;
    repeat (60) @(negedge mclk);
    read_chk(17'h08001, 8'h61);
    $display("test timeout done");
  endtask : t_timeout

  task automatic t_partial();
    do_program(10'h180, 8'h80, 5, 1'b0);
    read_chk(17'h0c004, 8'h84);
    $display("test partial done");
  endtask : t_partial

  ////////////////////////////////////////////////////////////////
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  initial begin
    repeat (30000) @(posedge mclk);
    failures++;
    $display("[ERR] watchdog expected done seen hang");
    finish_test();
  end

  initial begin
    failures = 0;
    comparisons = 0;
    nrst = 1'b0;
    req_valid = 1'b0;
    req = '0;
    wr_valid = 1'b0;
    wr_data = 8'h00;
    stall = 1'b0;
    saw_full = 1'b0;
    repeat (10) @(negedge mclk);
    t_reset();
    t_program();
    t_ident();
    t_lock();
    t_timeout();
    t_partial();
    finish_test();
  end
endmodule : sector_flash_program_protocol_tb

`default_nettype wire
